// ==== inc/pst_regs.vh ====
`ifndef PST_REGS_VH
`define PST_REGS_VH
`define PST_OFS_CHARGE      8'h1a
`define PST_OFS_TRIM        8'h1b
`define PST_OFS_FAULT       8'h1c
`define PST_RST_CHARGE      8'h00
`define PST_RST_TRIM        8'h00
`define PST_RST_FAULT       8'h00
`define PST_TRIM_LAUNCH     0
`define PST_TRIM_FIELD      1
`define PST_TRIM_DONE       6
`define PST_CLK_KHZ         25000
`define PST_CYC_PER_100US   2500
`define PST_FAULT_UNIT_100US 13
`define PST_FAULT_MAX_CODE  4'ha
`define PST_FAULT_ZERO_CYC  1000
`define PST_TRIM_CYC        16
`define PST_TRIM_MID        8'h80
`define PST_CHG_0           14'd1300
`define PST_CHG_1           14'd1690
`define PST_CHG_2           14'd2340
`define PST_CHG_3           14'd3120
`define PST_CHG_4           14'd4160
`define PST_CHG_5           14'd5460
`define PST_CHG_6           14'd7280
`define PST_CHG_7           14'd9620
`define PST_DIV_SHORT       100
`define PST_DIV_MID         10
`define PST_NCH             6
`endif

// ==== rtl/pst_ctrl.v ====
`include "pst_regs.vh"
module pst_ctrl #(
	parameter NCH = `PST_NCH
) (
	input  wire           mclk,
	input  wire           reset_n,
	input  wire           reg_wr,
	input  wire           reg_rd,
	input  wire [7:0]     reg_addr,
	input  wire [7:0]     reg_wdata,
	output reg  [7:0]     reg_rdata,
	input  wire           start_req,
	input  wire           split_cap_mode,
	input  wire [NCH-1:0] charge_select,
	input  wire [NCH-1:0] group1_member,
	input  wire [NCH-1:0] pwm_in,
	input  wire           osc_ref_in,
	input  wire [7:0]     factory_trim_value,
	input  wire           backend_fault_n,
	output reg  [NCH-1:0] pwm_out,
	output reg            group1_stage_enable,
	output reg            group2_stage_enable,
	output reg  [7:0]     osc_trim_value,
	output reg            osc_ref_out,
	output reg            fault_reset_req
);
	localparam S_IDLE   = 4'h1;
	localparam S_CHARGE = 4'h2;
	localparam S_RUN    = 4'h4;
	localparam S_FAULT  = 4'h8;

	// 1 ms = 25000 cycles; largest delay 9620 ms needs 28 bits
	localparam [31:0] MS_CYC = `PST_CLK_KHZ;

	reg  [7:0]  charge_code;
	reg  [7:0]  trim_ctrl;
	reg  [7:0]  fault_period;
	reg         trim_done;
	reg  [4:0]  trim_cnt;
	reg         trim_busy;
	reg  [3:0]  state;
	reg  [3:0]  next_state;
	reg  [31:0] wait_cnt;
	reg  [31:0] charge_cyc;
	reg  [31:0] fault_cyc;
	reg  [13:0] ms_x10;
	reg  [3:0]  fcode;
	wire        wait_done;

	always @* begin
		case (charge_code[2:0])
			3'h0: ms_x10 = `PST_CHG_0;
			3'h1: ms_x10 = `PST_CHG_1;
			3'h2: ms_x10 = `PST_CHG_2;
			3'h3: ms_x10 = `PST_CHG_3;
			3'h4: ms_x10 = `PST_CHG_4;
			3'h5: ms_x10 = `PST_CHG_5;
			3'h6: ms_x10 = `PST_CHG_6;
			default: ms_x10 = `PST_CHG_7;
		endcase
		case (charge_code[4:3])
			2'b01: charge_cyc = ms_x10 * MS_CYC / `PST_DIV_SHORT;
			2'b10: charge_cyc = ms_x10 * MS_CYC / `PST_DIV_MID;
			2'b11: charge_cyc = ms_x10 * MS_CYC;
			default: charge_cyc = 32'h0;
		endcase
		fcode = (fault_period[3:0] > `PST_FAULT_MAX_CODE) ?
			`PST_FAULT_MAX_CODE : fault_period[3:0];
		if (fcode == 4'h0)
			fault_cyc = `PST_FAULT_ZERO_CYC;
		else
			fault_cyc = fcode * `PST_FAULT_UNIT_100US * `PST_CYC_PER_100US;
	end

	assign wait_done = (wait_cnt <= 32'h1);

	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (start_req)
					next_state = S_CHARGE;
			end
			S_CHARGE: begin
				if (!split_cap_mode || charge_cyc == 32'h0 || wait_done)
					next_state = S_RUN;
			end
			S_RUN: begin
				if (!start_req)
					next_state = S_IDLE;
			end
			S_FAULT: begin
				if (wait_done)
					next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
		if (!backend_fault_n && state != S_FAULT)
			next_state = S_FAULT;
	end

	always @(posedge mclk) begin
		if (!reset_n) begin
			state           <= S_IDLE;
			wait_cnt        <= 32'h0;
			fault_reset_req <= 1'b0;
		end else begin
			state           <= next_state;
			fault_reset_req <= 1'b0;
			if (next_state != state) begin
				if (next_state == S_CHARGE)
					wait_cnt <= charge_cyc;
				else if (next_state == S_FAULT)
					wait_cnt <= fault_cyc;
				else
					wait_cnt <= 32'h0;
				if (state == S_FAULT)
					fault_reset_req <= 1'b1;
			end else if (wait_cnt != 32'h0)
				wait_cnt <= wait_cnt - 32'h1;
		end
	end

	// output stage; one generate per channel
	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			always @(posedge mclk) begin
				if (!reset_n)
					pwm_out[i] <= 1'b0;
				else if (next_state == S_RUN)
					pwm_out[i] <= pwm_in[i];
				else if (next_state == S_CHARGE)
					pwm_out[i] <= split_cap_mode & charge_select[i];
				else
					pwm_out[i] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge mclk) begin
		if (!reset_n) begin
			group1_stage_enable <= 1'b0;
			group2_stage_enable <= 1'b0;
		end else begin
			group1_stage_enable <= (next_state == S_RUN) && (|group1_member);
			group2_stage_enable <= (next_state == S_RUN) &&
				(|(~group1_member));
		end
	end

	always @(posedge mclk) begin
		if (!reset_n)
			osc_ref_out <= 1'b0;
		else
			osc_ref_out <= osc_ref_in;
	end

	// register file; trim bit 0 self-clears, a trim write wins over completion
	always @(posedge mclk) begin
		if (!reset_n) begin
			charge_code    <= `PST_RST_CHARGE;
			trim_ctrl      <= `PST_RST_TRIM;
			fault_period   <= `PST_RST_FAULT;
			trim_done      <= 1'b0;
			trim_busy      <= 1'b0;
			trim_cnt       <= 5'h0;
			osc_trim_value <= `PST_TRIM_MID;
		end else begin
			if (reg_wr && reg_addr == `PST_OFS_CHARGE)
				charge_code <= reg_wdata;
			if (reg_wr && reg_addr == `PST_OFS_FAULT)
				fault_period <= reg_wdata;
			if (reg_wr && reg_addr == `PST_OFS_TRIM) begin
				trim_ctrl <= reg_wdata & 8'h03;
				if (reg_wdata[`PST_TRIM_LAUNCH]) begin
					trim_busy <= 1'b1;
					trim_done <= 1'b0;
					trim_cnt  <= 5'h0;
				// plain write enables stored factory trim
				end else if (!reg_wdata[`PST_TRIM_FIELD]) begin
					osc_trim_value <= factory_trim_value;
					trim_done      <= 1'b1;
				end
			end else if (trim_busy) begin
				// field trim counts mclk cycles, not reference edges; a simple stand-in
				trim_cnt <= trim_cnt + 5'h1;
				if (trim_cnt == `PST_TRIM_CYC) begin
					trim_busy <= 1'b0;
					trim_done <= 1'b1;
					trim_ctrl[`PST_TRIM_LAUNCH] <= 1'b0;
					osc_trim_value <= trim_ctrl[`PST_TRIM_FIELD] ?
						`PST_TRIM_MID : factory_trim_value;
				end
			end
		end
	end

	always @(posedge mclk) begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				`PST_OFS_CHARGE: reg_rdata <= charge_code;
				`PST_OFS_TRIM:   reg_rdata <= {1'b0, trim_done, 4'h0,
					trim_ctrl[1:0]};
				`PST_OFS_FAULT:  reg_rdata <= fault_period;
				default:         reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// ==== verification/pst_stage_model.sv ====
module pst_stage_model (
	input  logic mclk,
	input  logic inject,
	output logic backend_fault_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] hold = 4'h0;
	// open-drain fault line with pull-up: idle high
	assign backend_fault_n = (hold == 4'h0);
	always @(posedge mclk)
		if (inject)
			hold <= 4'ha;
		else if (hold != 4'h0)
			hold <= hold - 4'h1;
endmodule

// ==== verification/pst_ctrl_props.sv ====
module pst_ctrl_props #(
	parameter NCH = 6
) (
	input logic           mclk,
	input logic           reset_n,
	input logic           reg_wr,
	input logic           reg_rd,
	input logic [7:0]     reg_addr,
	input logic [7:0]     reg_wdata,
	input logic [7:0]     reg_rdata,
	input logic           osc_ref_in,
	input logic           osc_ref_out,
	input logic           backend_fault_n,
	input logic [NCH-1:0] pwm_out,
	input logic           group1_stage_enable,
	input logic           group2_stage_enable,
	input logic           fault_reset_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	a_fault_clear: assert property (!backend_fault_n |=>
		pwm_out == '0 && !group1_stage_enable && !group2_stage_enable)
		else $error("outputs live in fault");
	a_no_early_req: assert property ($fell(backend_fault_n) |->
		!fault_reset_req [*8]) else $error("early reset request");
	a_req_pulse: assert property (fault_reset_req |=>
		!fault_reset_req) else $error("reset request too long");
	a_ref_follow: assert property ($rose(osc_ref_in) |=>
		osc_ref_out) else $error("reference lost");
	a_code_readback: assert property (reg_rd && reg_addr == 8'h1a &&
		$past(reg_wr, 2) && $past(reg_addr, 2) == 8'h1a |=>
		reg_rdata == $past(reg_wdata, 3)) else $error("code readback");
	a_trim_reserved: assert property (reg_rd && reg_addr == 8'h1b |=>
		reg_rdata[5:2] == 4'h0 && !reg_rdata[7]) else $error("trim bits");
	a_factory_done: assert property (reg_wr && reg_addr == 8'h1b &&
		reg_wdata == 8'h00 ##2 reg_rd && reg_addr == 8'h1b |=> reg_rdata[6])
		else $error("factory trim not done");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h1d |=>
		reg_rdata == 8'h00) else $error("unmapped read");
	cover property (fault_reset_req);
	cover property (group1_stage_enable && group2_stage_enable);
	cover property (reg_rd && reg_addr == 8'h1b);
endmodule
bind pst_ctrl pst_ctrl_props #(.NCH(NCH)) props (.mclk, .reset_n, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .osc_ref_in, .osc_ref_out,
	.backend_fault_n, .pwm_out, .group1_stage_enable, .group2_stage_enable,
	.fault_reset_req);

// ==== verification/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, inject = 0;
	logic       start_req = 0, split_cap_mode = 1, osc_ref_in = 0;
	logic       group1_stage_enable, group2_stage_enable, backend_fault_n;
	logic       fault_reset_req, osc_ref_out;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, factory_trim_value = 8'h3c;
	logic [7:0] reg_rdata, osc_trim_value;
	logic [5:0] charge_select = 6'h2a, group1_member = 6'h0c, pwm_in = 6'h15;
	logic [5:0] pwm_out;
	int         failures = 0, comparisons = 0, cyc = 0, n, x;
	logic [7:0] rows [4][3] = '{'{8'h1a, 8'h5a, 8'h5a}, '{8'h1c, 8'ha5, 8'ha5},
		'{8'h1d, 8'h77, 8'h00}, '{8'h1a, 8'h07, 8'h07}};
	pst_ctrl dut (.*);
	pst_stage_model far (.mclk, .inject, .backend_fault_n);
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc % 3 == 0)
			osc_ref_in <= #1 ~osc_ref_in;
		if (cyc == 60000) begin
			failures++;
			test_done();
		end
	end
	task automatic chk(input bit ok, input string m);
		comparisons++;
		if (!ok) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge mclk) #1 reg_wr = 0;
		// one idle edge so a following write never re-raises in this step
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, e, m);
		reg_addr = a;
		reg_rd = 1;
		@(posedge mclk) #1 reg_rd = 0;
		@(posedge mclk) #1 chk((reg_rdata & m) === e, "read");
	endtask
	task automatic test_done;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		tick(10);
		reset_n = 1;
		for (int i = 26; i < 29; i++)
			rd(8'(i), 8'h00, 8'hff);
		wr(8'h1b, 8'h00);
		rd(8'h1b, 8'h40, 8'hff);
		chk(osc_trim_value === factory_trim_value, "factory");
		wr(8'h05, 8'h20);
		wr(8'h07, 8'h30);
		// a second reset must forget the trim
		reset_n = 0;
		tick(2);
		reset_n = 1;
		rd(8'h1b, 8'h00, 8'h40);
		wr(8'h00, 8'h6d);
		wr(8'h1b, 8'h03);
		tick(40);
		rd(8'h1b, 8'h42, 8'h7e);
		foreach (rows[i]) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], rows[i][2], 8'hff);
		end
		for (int k = 0; k < 2; k++) begin
			if (k) wr(8'h1a, 8'h08);
			split_cap_mode = !k;
			group1_member = k ? 6'h3f : 6'h0c;
			start_req = 1;
			tick(4);
			chk(pwm_out === pwm_in && group1_stage_enable === 1'b1
				&& group2_stage_enable === (k == 0), "run");
			start_req = 0;
			tick(4);
		end
		split_cap_mode = 1;
		start_req = 1;
		tick(4);
		chk({pwm_out, group1_stage_enable, group2_stage_enable}
			=== 8'ha8, "chg");
		pwm_in = 6'h2b;
		tick(20);
		chk(pwm_out === charge_select, "static");
		for (int k = 0; k < 2; k++) begin
			wr(8'h1c, 8'(k));
			inject = 1;
			tick(1);
			inject = 0;
			tick(1);
			chk({pwm_out, group1_stage_enable, group2_stage_enable}
				=== 8'h00, "clr");
			x = k ? 32500 : 1000;
			for (n = 1; fault_reset_req !== 1'b1 && n < 40000; n++)
				tick(1);
			chk(n >= x - 4 && n <= x + 4, "wait");
		end
		test_done();
	end
endmodule
